// *** cro_consts.svh ***
// constants for the cmos reference clock output selector
//
// Summary of operation
// (RL1) Power-down pin high forces both auxiliary outputs off, whatever the configuration.
// (RL2) Straps set the outputs at power-up; register mode fields replace them under override.
// (RL3) Straps pick the first output's divider; for the second they only switch it on.
// (RL4) A selected reference clock function wins over over-range on that pin.
// (RL5) The second output's clock function needs a nonzero first output code.
// (RL6) First output: code 0 off or over-range C, codes 1..3 give divide 1, 2, 4.
// (RL7) Second output: strap 0 off or over-range, else undivided; mode 0..3 as first.
// (RL8) Dual and single variants keep over-range codes disabled.
// (RL9) Timing reference is captured on a reference clock rising edge.
// (RL10) External reference is one pulse or periodic at a multiframe clock division.
// (RL11) 8b/10b periodic reference equals R times device clock over 10*F*K*n.
// (RL12) 64b/66b periodic reference denominator is 66*32*E*n.
// (RL13) Reference clock comes from the differential or single-ended input by select pin.
// (RL14) Dividers reset in power-down and change ratio only at a divided boundary.
`ifndef CRO_CONSTS_SVH
`define CRO_CONSTS_SVH

// ****************************************
// register map
// ****************************************
`define CRO_ADDR_W 12
`define CRO_OFS_CTRL 12'h000
`define CRO_OFS_STATUS 12'h004
`define CRO_OFS_SYSREF 12'h008
`define CRO_CTRL_RESET 6'h00
`define CRO_BIT_OVERRIDE 0
`define CRO_BIT_OVERRANGE_ENABLE 1
`define CRO_FLD_FIRST_LO 2
`define CRO_FLD_SECOND_LO 4

// ****************************************
// codes and counts
// ****************************************
`define CRO_CODE_OFF 2'h0
`define CRO_CODE_DIV1 2'h1
`define CRO_CODE_DIV2 2'h2
`define CRO_CODE_DIV4 2'h3
`define CRO_CNT_ZERO 2'h0
`define CRO_CNT_ONE 2'h1
`define CRO_QUAD_CHANNELS 4
`define CRO_NUM_OUTS 2

`endif

// *** cro_output_select.sv ***
// auxiliary cmos reference clock output selector with apb registers
`timescale 1ns/100ps
`include "cro_consts.svh"
module cro_output_select
#(
	parameter int CHANNELS = `CRO_QUAD_CHANNELS
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic power_down_pin,
	input wire logic [1:0] clock_cfg_straps,
	input wire logic refclk_source_select,
	input wire logic diff_refclk,
	input wire logic se_refclk,
	input wire logic overrange_c,
	input wire logic overrange_d,
	input wire logic sysref,
	output logic aux_out_first,
	output logic aux_out_second,
	output logic sysref_captured
);
	logic [5:0] ctrl;
	logic [15:0] sysref_count;
	logic ref_q;
	logic ref_prev;
	logic ref_rise;
	logic sysref_prev;
	logic access;
	logic [`CRO_ADDR_W-1:0] addr;
	cro_pkg::cro_func_t next_func [`CRO_NUM_OUTS];
	cro_pkg::cro_func_t func [`CRO_NUM_OUTS];
	logic [1:0] ratio [`CRO_NUM_OUTS];
	logic [`CRO_NUM_OUTS-1:0] div_out;
	logic [`CRO_NUM_OUTS-1:0] ovr_in;
	logic [`CRO_NUM_OUTS-1:0] aux_q;
	logic override;
	logic ovr_allowed;
	logic [1:0] first_code;
	logic [1:0] second_code;

	assign addr = paddr[`CRO_ADDR_W-1:0];
	assign access = psel & penable & pready;
	assign override = ctrl[`CRO_BIT_OVERRIDE];
	assign ovr_allowed = ctrl[`CRO_BIT_OVERRANGE_ENABLE] && (CHANNELS == `CRO_QUAD_CHANNELS); // RL8
	assign ovr_in = {overrange_d, overrange_c};
	assign ref_rise = ref_q & ~ref_prev;

	// ****************************************
	// apb slave, no wait states
	// ****************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pready <= 1'b0;
		else
			pready <= psel & ~penable;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end
		else if (psel & ~penable)
		begin
			pslverr <= !(addr == `CRO_OFS_CTRL || addr == `CRO_OFS_STATUS || addr == `CRO_OFS_SYSREF);
			case (addr)
				`CRO_OFS_CTRL: prdata <= {26'h0000000, ctrl};
				`CRO_OFS_STATUS: prdata <= {22'h000000, refclk_source_select, power_down_pin,
					clock_cfg_straps, func[1], func[0]};
				`CRO_OFS_SYSREF: prdata <= {16'h0000, sysref_count};
				default: prdata <= 32'h00000000;
			endcase
		end
		else if (!psel)
		begin
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ctrl <= `CRO_CTRL_RESET;
		else if (access && pwrite && addr == `CRO_OFS_CTRL)
			ctrl <= pwdata[5:0];
	end

	// ****************************************
	// reference clock pick and edge detect
	// ****************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ref_q <= 1'b0;
			ref_prev <= 1'b0;
		end
		else
		begin
			ref_q <= refclk_source_select ? se_refclk : diff_refclk; // RL13
			ref_prev <= ref_q;
		end
	end

	// ****************************************
	// function decode
	// ****************************************
	always_comb
	begin
		first_code = override ? ctrl[`CRO_FLD_FIRST_LO +: 2] : clock_cfg_straps; // RL2 RL3
		if (override)
			second_code = ctrl[`CRO_FLD_SECOND_LO +: 2]; // RL7
		else if (clock_cfg_straps == `CRO_CODE_OFF)
			second_code = `CRO_CODE_OFF;
		else
			second_code = `CRO_CODE_DIV1; // RL3
		for (int i = 0; i < `CRO_NUM_OUTS; i++)
		begin
			case (i == 0 ? first_code : second_code) // RL4 RL6 RL7
				`CRO_CODE_DIV1: next_func[i] = cro_pkg::CRO_FN_DIV1;
				`CRO_CODE_DIV2: next_func[i] = cro_pkg::CRO_FN_DIV2;
				`CRO_CODE_DIV4: next_func[i] = cro_pkg::CRO_FN_DIV4;
				default: next_func[i] = ovr_allowed ? cro_pkg::CRO_FN_OVR : cro_pkg::CRO_FN_OFF;
			endcase
		end
		if (first_code == `CRO_CODE_OFF && next_func[1] != cro_pkg::CRO_FN_OVR)
			next_func[1] = cro_pkg::CRO_FN_OFF; // RL5
		if (power_down_pin)
		begin
			next_func[0] = cro_pkg::CRO_FN_OFF; // RL1
			next_func[1] = cro_pkg::CRO_FN_OFF; // RL1
		end
	end

	// ****************************************
	// per output divider and pin register
	// ****************************************
	genvar g;
	generate
		for (g = 0; g < `CRO_NUM_OUTS; g++)
		begin : g_out
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					func[g] <= cro_pkg::CRO_FN_OFF;
				else
					func[g] <= next_func[g];
			end

			always_comb
			begin
				case (func[g])
					cro_pkg::CRO_FN_DIV2: ratio[g] = `CRO_CODE_DIV2;
					cro_pkg::CRO_FN_DIV4: ratio[g] = `CRO_CODE_DIV4;
					default: ratio[g] = `CRO_CODE_DIV1;
				endcase
			end

			cro_refdiv u_div
			(
				.pclk(pclk),
				.presetn(presetn),
				.clear(power_down_pin),
				.ref_level(ref_q),
				.ref_rise(ref_rise),
				.ratio(ratio[g]),
				.div_out(div_out[g])
			);

			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					aux_q[g] <= 1'b0;
				else if (power_down_pin)
					aux_q[g] <= 1'b0; // RL1
				else
				begin
					case (func[g])
						cro_pkg::CRO_FN_OFF: aux_q[g] <= 1'b0;
						cro_pkg::CRO_FN_OVR: aux_q[g] <= ovr_in[g];
						default: aux_q[g] <= div_out[g]; // RL4
					endcase
				end
			end
		end
	endgenerate

	assign aux_out_first = aux_q[0];
	assign aux_out_second = aux_q[1];

	// ****************************************
	// timing reference capture
	// ****************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sysref_prev <= 1'b0;
			sysref_captured <= 1'b0;
		end
		else
		begin
			if (ref_rise)
				sysref_prev <= sysref;
			sysref_captured <= ref_rise & sysref & ~sysref_prev; // RL9
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			sysref_count <= 16'h0000;
		else if (sysref_captured)
			sysref_count <= sysref_count + 16'h0001;
	end

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_pd_forces_off: assert property (power_down_pin |=> ##1 !aux_out_first && !aux_out_second) // RL1
		else $error("output active during power-down");
	a_strap_div_first: assert property (!override && !power_down_pin && clock_cfg_straps == 2'h2
		|=> func[0] == cro_pkg::CRO_FN_DIV2) // RL2
		else $error("first output ignores straps");
	a_strap_on_second: assert property (!override && !power_down_pin && clock_cfg_straps == 2'h3
		|=> func[1] == cro_pkg::CRO_FN_DIV1) // RL3
		else $error("second output divided by straps");
	a_clock_over_ovr: assert property (func[0] == cro_pkg::CRO_FN_DIV1 && !power_down_pin
		|=> aux_out_first == $past(div_out[0])) // RL4
		else $error("clock function lost priority");
	a_second_needs_first: assert property (first_code == 2'h0 |=> func[1] != cro_pkg::CRO_FN_DIV1
		&& func[1] != cro_pkg::CRO_FN_DIV2 && func[1] != cro_pkg::CRO_FN_DIV4) // RL5
		else $error("second clock without first");
	a_mode_first_map: assert property (override && !power_down_pin && ctrl[3:2] == 2'h3
		|=> func[0] == cro_pkg::CRO_FN_DIV4) // RL6
		else $error("first mode mapping wrong");
	a_mode_second_map: assert property (override && !power_down_pin && ctrl[3:2] != 2'h0 && ctrl[5:4] == 2'h2
		|=> func[1] == cro_pkg::CRO_FN_DIV2) // RL7
		else $error("second mode mapping wrong");
	a_ovr_variant: assert property ((CHANNELS != `CRO_QUAD_CHANNELS) |-> func[0] != cro_pkg::CRO_FN_OVR
		&& func[1] != cro_pkg::CRO_FN_OVR) // RL8
		else $error("over-range on non-quad variant");
	a_sysref_edge: assert property (sysref_captured |-> $past(ref_rise) && $past(sysref)) // RL9
		else $error("timing reference captured off edge");
	a_refsel_pick: assert property (refclk_source_select |=> ref_q == $past(se_refclk)) // RL13
		else $error("wrong reference source");
	a_div_clear: assert property (power_down_pin |=> !div_out[0] && !div_out[1]) // RL14
		else $error("divider not cleared");

	c_first_div4: cover property (func[0] == cro_pkg::CRO_FN_DIV4 ##1 aux_out_first);
	c_second_on: cover property (func[1] == cro_pkg::CRO_FN_DIV1 ##1 aux_out_second);
	c_ovr_shown: cover property (func[0] == cro_pkg::CRO_FN_OVR && overrange_c ##1 aux_out_first);
	c_sysref_cap: cover property (sysref_captured);
endmodule // cro_output_select

// *** cro_pkg.sv ***
// types of the cmos reference clock output selector
package cro_pkg;
	typedef enum logic [2:0] {
		CRO_FN_OFF = 3'b000,
		CRO_FN_OVR = 3'b001,
		CRO_FN_DIV1 = 3'b010,
		CRO_FN_DIV2 = 3'b011,
		CRO_FN_DIV4 = 3'b100
	} cro_func_t;
endpackage

// *** cro_refdiv.sv ***
// reference clock divider for one auxiliary output
`timescale 1ns/100ps
`include "cro_consts.svh"
module cro_refdiv
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clear,
	input wire logic ref_level,
	input wire logic ref_rise,
	input wire logic [1:0] ratio,
	output logic div_out
);
	logic [1:0] cnt;
	logic [1:0] active_ratio;

	// ****************************************
	// edge counter, held clear in power-down
	// ****************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cnt <= `CRO_CNT_ZERO;
		else if (clear)
			cnt <= `CRO_CNT_ZERO; // RL14
		else if (ref_rise)
			cnt <= cnt + `CRO_CNT_ONE;
	end

	// ratio is only taken up where all divided phases restart
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			active_ratio <= `CRO_CODE_DIV1;
		else if (clear || (ref_rise && cnt == `CRO_CNT_ZERO))
			active_ratio <= ratio; // RL14
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			div_out <= 1'b0;
		else if (clear)
			div_out <= 1'b0;
		else
		begin
			case (active_ratio)
				`CRO_CODE_DIV2: div_out <= cnt[0];
				`CRO_CODE_DIV4: div_out <= cnt[1];
				default: div_out <= ref_level;
			endcase
		end
	end
endmodule // cro_refdiv

// *** cro_refsrc.sv ***
// far-side model: free-running reference clocks and a one-shot or periodic timing reference
`timescale 1ns/100ps
module cro_refsrc
#(
	parameter int HALF_DIFF = 4,
	parameter int HALF_SE = 6,
	parameter int LINK_R = 4,
	parameter int FRAME_F = 1,
	parameter int MF_K = 4,
	parameter int EXT_E = 1,
	parameter int MULT_N = 1,
	parameter int ENC66 = 0
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic fire,
	input wire logic periodic,
	output logic diff_refclk,
	output logic se_refclk,
	output logic sysref
);
	int cd;
	int cs;
	int hold;
	int rc;
	logic armed;
	// periodic timing reference period in reference clock cycles
	localparam int SYS_PER_8B = 10 * FRAME_F * MF_K * MULT_N / LINK_R;
	localparam int SYS_PER_64B = 66 * 32 * EXT_E * MULT_N / LINK_R;
	localparam int SYS_PER = ENC66 ? SYS_PER_64B : SYS_PER_8B;
	// ****************************************
	// reference clocks
	// ****************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cd <= 0;
			cs <= 0;
			diff_refclk <= 1'b0;
			se_refclk <= 1'b0;
		end
		else
		begin
			cd <= (cd == HALF_DIFF - 1) ? 0 : cd + 1;
			cs <= (cs == HALF_SE - 1) ? 0 : cs + 1;
			if (cd == HALF_DIFF - 1)
				diff_refclk <= !diff_refclk;
			if (cs == HALF_SE - 1)
				se_refclk <= !se_refclk;
		end
	end
	// ****************************************
	// single timing pulse or periodic clock, launched at reference falls
	// ****************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			armed <= 1'b0;
			hold <= 0;
			rc <= 0;
			sysref <= 1'b0;
		end
		else if (periodic)
		begin
			// periodic mode: half-duty clock launched at reference falls
			if (diff_refclk && cd == HALF_DIFF - 1)
			begin
				rc <= (rc == SYS_PER - 1) ? 0 : rc + 1;
				sysref <= (rc < SYS_PER / 2);
			end
		end
		else
		begin
			if (fire)
				armed <= 1'b1;
			if (armed && diff_refclk && cd == HALF_DIFF - 1)
			begin
				armed <= 1'b0;
				sysref <= 1'b1;
				hold <= 4 * HALF_DIFF;
			end
			else if (hold > 0)
			begin
				hold <= hold - 1;
				if (hold == 1)
					sysref <= 1'b0;
			end
			else
				sysref <= 1'b0;
		end
	end
endmodule // cro_refsrc

// *** tb_top.sv ***
// self-checking bench for the cmos reference clock output selector
`timescale 1ns/100ps
module tb_top;
	logic pclk, presetn, psel, penable, pwrite, power_down_pin, rsel, ovc, ovd, fire, periodic;
	logic [31:0] paddr, pwdata, prdata, rv;
	logic pready, pslverr, re, df, se, sr, aux_out_first, aux_out_second, cap;
	logic aux_dual_first, aux_dual_second;
	logic [1:0] clock_cfg_straps;
	int fails, n_tests, cyc, p, ncap, lastc, gapc;
	cro_refsrc src (.pclk(pclk), .presetn(presetn), .fire(fire), .periodic(periodic), .diff_refclk(df),
		.se_refclk(se), .sysref(sr));
	cro_output_select dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.power_down_pin(power_down_pin), .clock_cfg_straps(clock_cfg_straps), .refclk_source_select(rsel),
		.diff_refclk(df), .se_refclk(se), .overrange_c(ovc), .overrange_d(ovd), .sysref(sr),
		.aux_out_first(aux_out_first), .aux_out_second(aux_out_second), .sysref_captured(cap));
	// dual-channel variant on the same stimulus: over-range must never show
	cro_output_select #(.CHANNELS(2)) dut_dual (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(), .pready(), .pslverr(),
		.power_down_pin(power_down_pin), .clock_cfg_straps(clock_cfg_straps), .refclk_source_select(rsel),
		.diff_refclk(df), .se_refclk(se), .overrange_c(ovc), .overrange_d(ovd), .sysref(sr),
		.aux_out_first(aux_dual_first), .aux_out_second(aux_dual_second), .sysref_captured());
	initial
	begin
		pclk = 1'b0;
		forever #5 pclk = !pclk;
	end
	always @(posedge pclk)
	begin
		cyc++;
		if (cap === 1'b1)
		begin
			ncap++;
			gapc = cyc - lastc;
			lastc = cyc;
		end
		if (cyc == 20000)
		begin
			fails++;
			wrap_up;
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
	begin
		n_tests++;
		if (got !== exp)
		begin
			fails++;
			$display("mismatch t=%0t %s got %h exp %h", $time, m, got, exp);
		end
	end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
	begin
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {20'h00000, a};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
		end
		while (pready !== 1'b1);
		rv = prdata;
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	end
	endtask
	// period between two rises of one pin, 0 when it never toggles
	task automatic per(input bit w, output int q);
		logic v, o;
		int n, f, e;
	begin
		repeat (40) @(posedge pclk);
		o = 1'b1;
		e = 0;
		q = 0;
		for (n = 0; n < 200 && e < 2; n++)
		begin
			@(posedge pclk);
			v = w ? aux_out_second : aux_out_first;
			if (v === 1'b1 && o === 1'b0)
			begin
				if (e == 1)
					q = n - f;
				f = n;
				e++;
			end
			o = v;
		end
	end
	endtask
	function automatic int pe(int c);
		return (c == 0) ? 0 : 8 << (c - 1);
	endfunction
	task automatic t_straps;
	begin
		for (int s = 0; s < 4; s++)
		begin
			clock_cfg_straps <= 2'(s);
			per(0, p);
			chk(32'(p), 32'(pe(s)), "strap first");
			per(1, p);
			chk(32'(p), 32'((s == 0) ? 0 : 8), "strap second");
		end
		$display("test straps done");
	end
	endtask
	task automatic t_override;
	begin
		clock_cfg_straps <= 2'h3;
		for (int c = 0; c < 4; c++)
		begin
			apb(1'b1, 12'h000, 32'((3 - c) * 16 + c * 4 + 1));
			per(0, p);
			chk(32'(p), 32'(pe(c)), "mode first");
			per(1, p);
			chk(32'(p), 32'((c == 0) ? 0 : pe(3 - c)), "mode second");
		end
		$display("test override done");
	end
	endtask
	task automatic t_ovr;
	begin
		apb(1'b1, 12'h000, 32'h00000002);
		clock_cfg_straps <= 2'h0;
		ovc <= 1'b1;
		ovd <= 1'b1;
		repeat (4) @(posedge pclk);
		chk(32'(aux_out_first), 32'h1, "ovr first");
		chk(32'(aux_out_second), 32'h1, "ovr second");
		chk(32'({aux_dual_first, aux_dual_second}), 32'h0, "ovr dual");
		apb(1'b0, 12'h004, 32'h0);
		chk(rv, 32'h00000009, "status ovr");
		ovc <= 1'b0;
		repeat (4) @(posedge pclk);
		chk(32'(aux_out_first), 32'h0, "ovr clear");
		clock_cfg_straps <= 2'h1;
		ovc <= 1'b1;
		per(0, p);
		chk(32'(p), 32'h8, "clock over ovr");
		ovc <= 1'b0;
		ovd <= 1'b0;
		apb(1'b1, 12'h000, 32'h00000000);
		$display("test overrange done");
	end
	endtask
	task automatic t_pd;
		int n;
	begin
		clock_cfg_straps <= 2'h3;
		power_down_pin <= 1'b1;
		repeat (3) @(posedge pclk);
		n = 0;
		repeat (40)
		begin
			@(posedge pclk);
			n += int'(aux_out_first !== 1'b0) + int'(aux_out_second !== 1'b0);
		end
		chk(32'(n), 32'h0, "power down");
		power_down_pin <= 1'b0;
		per(0, p);
		chk(32'(p), 32'h20, "after power down");
		$display("test power down done");
	end
	endtask
	task automatic t_bus;
	begin
		apb(1'b0, 12'h000, 32'h0);
		chk(rv, 32'h0, "ctrl reset");
		apb(1'b1, 12'h00C, 32'h0000003F);
		chk(32'(re), 32'h1, "unmapped write");
		apb(1'b0, 12'h00C, 32'h0);
		chk({rv[30:0], re}, 32'h1, "unmapped read");
		apb(1'b0, 12'h000, 32'h0);
		chk(rv, 32'h0, "ctrl kept");
		$display("test bus done");
	end
	endtask
	task automatic t_sync;
	begin
		ncap = 0;
		fire <= 1'b1;
		@(posedge pclk);
		fire <= 1'b0;
		repeat (80) @(posedge pclk);
		chk(32'(ncap), 32'h1, "capture pulse");
		apb(1'b0, 12'h008, 32'h0);
		chk({16'h0000, rv[15:0]}, 32'h1, "capture count");
		periodic <= 1'b1;
		repeat (300) @(posedge pclk);
		periodic <= 1'b0;
		chk(32'(gapc), 32'h50, "periodic ref");
		rsel <= 1'b1;
		clock_cfg_straps <= 2'h1;
		per(0, p);
		chk(32'(p), 32'hC, "single-ended ref");
		rsel <= 1'b0;
		$display("test sysref done");
	end
	endtask
	task automatic wrap_up;
	begin
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	end
	endtask
	initial
	begin
		{presetn, psel, penable, pwrite, power_down_pin, rsel, ovc, ovd, fire, periodic} = 10'h000;
		{paddr, pwdata, clock_cfg_straps} = 66'h0;
		{fails, n_tests, cyc, ncap} = 0;
		repeat (12) @(posedge pclk);
		chk({aux_out_first, aux_out_second, cap}, 32'h0, "reset pins");
		presetn <= 1'b1;
		@(posedge pclk);
		t_bus;
		t_straps;
		t_override;
		t_ovr;
		t_pd;
		t_sync;
		wrap_up;
	end
endmodule // tb_top
